// [design/qdl_pkg.sv]
package qdl_pkg;

    // ************************************************************
    // Command word layout
    // ************************************************************
    localparam int WORD_BITS    = 16;
    localparam int CH_HI_POS    = 15;   // channel_select_hi
    localparam int CH_LO_POS    = 14;   // channel_select_lo
    localparam int PD_N_POS     = 13;   // power_down_n_bit
    localparam int LOAD_N_POS   = 12;   // load_all_n_bit
    localparam int DATA_MSB_POS = 11;
    localparam int MAX_DATA     = 12;
    localparam int NUM_CH       = 4;

    // Bit counter of the receiver
    localparam logic [4:0] BIT_CNT_RST  = 5'h00;
    localparam logic [4:0] BIT_CNT_LAST = 5'h0F;
    localparam logic [4:0] BIT_CNT_DONE = 5'h10;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [MAX_DATA-1:0]  DATA_RST = 12'h000;
    localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
    localparam logic                 HIZ_RST  = 1'b0;
    localparam logic                 SETL_RST = 1'b1;
    localparam logic                 BUF_RST  = 1'b1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int WAKE_5V_NS    = 2500;
    localparam int WAKE_3V_NS    = 5000;
    // Longest times round down, never below one cycle
    localparam int WAKE_5V_RAW   = WAKE_5V_NS / CLK_PERIOD_NS;
    localparam int WAKE_3V_RAW   = WAKE_3V_NS / CLK_PERIOD_NS;
    localparam int WAKE_5V_CYC   = (WAKE_5V_RAW < 1) ? 1 : WAKE_5V_RAW;
    localparam int WAKE_3V_CYC   = (WAKE_3V_RAW < 1) ? 1 : WAKE_3V_RAW;
    localparam int WAKE_CNT_BITS = 8;
    localparam logic [WAKE_CNT_BITS-1:0] WAKE_CNT_RST = 8'h00;

    // ************************************************************
    // Output power state, Gray along on -> down -> wake
    // ************************************************************
    typedef enum logic [1:0] {
        QDL_ON   = 2'b00,
        QDL_DOWN = 2'b01,
        QDL_WAKE = 2'b11
    } qdl_pwr_state_t;

endpackage : qdl_pkg

// [design/qdl_quad_dac_serial_loader.sv]
module qdl_quad_dac_serial_loader
    import qdl_pkg::*;
#(
    parameter int DATA_BITS  = 12,
    parameter bit LOW_SUPPLY = 1'b0
) (
    input  wire logic                 clock_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 sclk_i,
    input  wire logic                 sync_n_i,
    input  wire logic                 sdata_i,
    output logic [DATA_BITS-1:0]      dac_a_o,
    output logic [DATA_BITS-1:0]      dac_b_o,
    output logic [DATA_BITS-1:0]      dac_c_o,
    output logic [DATA_BITS-1:0]      dac_d_o,
    output logic                      outputs_hiz_o,
    output logic                      output_settled_o,
    output logic                      input_buffer_on_o
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (DATA_BITS != 8 && DATA_BITS != 10 && DATA_BITS != 12) begin : g_chk
        $error("DATA_BITS must be 8, 10 or 12");
    end

    localparam logic [WAKE_CNT_BITS-1:0] WAKE_LAST = LOW_SUPPLY ?
        WAKE_CNT_BITS'(WAKE_3V_CYC - 1) : WAKE_CNT_BITS'(WAKE_5V_CYC - 1);

    logic [WORD_BITS-1:0]  word;
    logic                  link_tgl;
    logic                  tgl_s1_q;
    logic                  tgl_s2_q;
    logic                  tgl_s3_q;
    logic                  sync_s1_q;
    logic                  sync_s2_q;
    logic                  sync_s3_q;
    logic                  frame_evt;
    logic                  sync_fall;
    logic [1:0]            wr_ch;
    logic                  wr_pd_n;
    logic                  wr_load_n;
    logic [DATA_BITS-1:0]  wr_data;
    logic [DATA_BITS-1:0]  in_q  [NUM_CH];
    logic [DATA_BITS-1:0]  dac_q [NUM_CH];
    logic [NUM_CH-1:0]     chg_q;
    qdl_pwr_state_t        pwr_q;
    logic [WAKE_CNT_BITS-1:0] wake_cnt_q;
    logic                  hiz_q;
    logic                  settled_q;
    logic                  buf_on_q;

    // ************************************************************
    // Link-side receiver on the serial clock
    // ************************************************************
    qdl_serial_rx u_rx (
        .sclk_i      (sclk_i),
        .rst_b_i     (rst_b_i),
        .sync_n_i    (sync_n_i),
        .sdata_i     (sdata_i),
        .word_o      (word),
        .frame_tgl_o (link_tgl)
    );

    // ************************************************************
    // Clock domain crossing
    // ************************************************************
    // Word-complete toggle, two stages then an edge stage
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= link_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // Frame sync pin, two stages then an edge stage
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_s1_q <= 1'b1;
            sync_s2_q <= 1'b1;
            sync_s3_q <= 1'b1;
        end else begin
            sync_s1_q <= sync_n_i;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
        end
    end

    // Word is stable here: the link holds it until the next frame
    assign frame_evt = tgl_s2_q ^ tgl_s3_q;
    assign sync_fall = sync_s3_q & ~sync_s2_q;

    // ************************************************************
    // Field decode
    // ************************************************************
    assign wr_ch     = {word[CH_HI_POS], word[CH_LO_POS]};
    assign wr_pd_n   = word[PD_N_POS];
    assign wr_load_n = word[LOAD_N_POS];
    // Top DATA_BITS of the data field, low bits dropped
    assign wr_data   = word[DATA_MSB_POS -: DATA_BITS];

    // ************************************************************
    // Input and DAC registers
    // ************************************************************
    // Input registers take the addressed word on completion
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                in_q[i] <= DATA_RST[DATA_BITS-1:0];
            end
        end else if (frame_evt) begin
            in_q[wr_ch] <= wr_data;
        end
    end

    // DAC registers move only on a load-all word
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                dac_q[i] <= DATA_RST[DATA_BITS-1:0];
            end
        end else if (frame_evt && !wr_load_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_ch == 2'(i)) begin
                    dac_q[i] <= wr_data;
                end else if (chg_q[i]) begin
                    dac_q[i] <= in_q[i];
                end
            end
        end
    end

    // Written-since-update flags
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chg_q <= '0;
        end else if (frame_evt) begin
            if (!wr_load_n) begin
                chg_q <= '0;
            end else begin
                chg_q[wr_ch] <= 1'b1;
            end
        end
    end

    assign dac_a_o = dac_q[0];
    assign dac_b_o = dac_q[1];
    assign dac_c_o = dac_q[2];
    assign dac_d_o = dac_q[3];

    // ************************************************************
    // Power-down and wake timing
    // ************************************************************
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwr_q      <= QDL_ON;
            wake_cnt_q <= WAKE_CNT_RST;
            hiz_q      <= HIZ_RST;
            settled_q  <= SETL_RST;
        end else if (frame_evt && !wr_pd_n) begin
            pwr_q     <= QDL_DOWN;
            hiz_q     <= 1'b1;
            settled_q <= 1'b0;
        end else begin
            case (pwr_q)
                QDL_DOWN: begin
                    if (frame_evt) begin
                        pwr_q      <= QDL_WAKE;
                        hiz_q      <= 1'b0;
                        wake_cnt_q <= WAKE_CNT_RST;
                    end
                end
                QDL_WAKE: begin
                    if (wake_cnt_q == WAKE_LAST) begin
                        pwr_q     <= QDL_ON;
                        settled_q <= 1'b1;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 8'h01;
                    end
                end
                QDL_ON: begin
                    pwr_q <= QDL_ON;
                end
                default: begin
                    pwr_q <= QDL_ON;
                end
            endcase
        end
    end

    assign outputs_hiz_o    = hiz_q;
    assign output_settled_o = settled_q;

    // ************************************************************
    // Serial input buffer gating
    // ************************************************************
    // A new frame start wins over a completion in the same cycle
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buf_on_q <= BUF_RST;
        end else if (sync_fall) begin
            buf_on_q <= 1'b1;
        end else if (frame_evt) begin
            buf_on_q <= 1'b0;
        end
    end

    assign input_buffer_on_o = buf_on_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_input_hold: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        !frame_evt |=> $stable(in_q[0]) && $stable(in_q[3]))
        else $error("input register changed without a word");

    a_input_load: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && wr_ch == 2'b01 |=> in_q[1] == $past(wr_data))
        else $error("addressed input register not loaded");

    a_load_all_n_bit_high_hold: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && wr_load_n |=> $stable(dac_q[0]) && $stable(dac_q[1])
            && $stable(dac_q[2]) && $stable(dac_q[3]))
        else $error("DAC register moved on load-all high");

    a_load_all_n_bit_low_new: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && !wr_load_n && wr_ch == 2'b11
            |=> dac_d_o == $past(wr_data))
        else $error("simultaneous update missed new data");

    a_load_all_n_bit_low_all: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && !wr_load_n && wr_ch != 2'b00 && chg_q[0]
            |=> dac_a_o == $past(in_q[0]))
        else $error("changed channel not updated");

    a_unchanged_skip: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && !wr_load_n && wr_ch != 2'b01 && !chg_q[1]
            |=> $stable(dac_b_o))
        else $error("unchanged channel refreshed");

    a_pd_enter: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && !wr_pd_n |=> outputs_hiz_o && !output_settled_o)
        else $error("power-down not entered");

    a_pd_leave: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && wr_pd_n |=> !outputs_hiz_o)
        else $error("power-down not left");

    a_pd_keep: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        outputs_hiz_o && !frame_evt |=> $stable(dac_c_o)
            && $stable(in_q[2]))
        else $error("registers lost in power-down");

    a_wake_delay: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(output_settled_o) |-> $past(pwr_q) == QDL_WAKE
            && $past(wake_cnt_q) == WAKE_LAST)
        else $error("output settled at the wrong time");

    a_buf_off: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        frame_evt && !sync_fall |=> !input_buffer_on_o)
        else $error("input buffers left on after word");

    a_buf_on: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        sync_fall |=> input_buffer_on_o)
        else $error("input buffers not on at frame start");

    // A tristated output is never reported as settled
    a_hiz_unsettled: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        outputs_hiz_o |-> !output_settled_o)
        else $error("output settled while tristated");

endmodule : qdl_quad_dac_serial_loader

// [design/qdl_serial_rx.sv]
module qdl_serial_rx
    import qdl_pkg::*;
(
    input  wire logic                 sclk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 sync_n_i,
    input  wire logic                 sdata_i,
    output logic [WORD_BITS-1:0]      word_o,
    output logic                      frame_tgl_o
);

    logic [4:0]           bit_cnt_q;
    logic [WORD_BITS-1:0] shift_q;
    logic                 tgl_q;
    logic                 frame_clr_b;

    // Frame sync high or power-on reset clears the frame
    assign frame_clr_b = rst_b_i & ~sync_n_i;

    // ************************************************************
    // Bit counter, stops at sixteen
    // ************************************************************
    always_ff @(negedge sclk_i or negedge frame_clr_b) begin
        if (!frame_clr_b) begin
            bit_cnt_q <= BIT_CNT_RST;
        end else if (bit_cnt_q != BIT_CNT_DONE) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Shift on falling sclk, MSB first, stop after sixteen
    always_ff @(negedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_q <= WORD_RST;
        end else if (!sync_n_i && bit_cnt_q != BIT_CNT_DONE) begin
            shift_q <= {shift_q[WORD_BITS-2:0], sdata_i};
        end
    end

    // Completed word is flagged by a toggle on the sixteenth edge
    always_ff @(negedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tgl_q <= 1'b0;
        end else if (!sync_n_i && bit_cnt_q == BIT_CNT_LAST) begin
            tgl_q <= ~tgl_q;
        end
    end

    assign word_o      = shift_q;
    assign frame_tgl_o = tgl_q;

endmodule : qdl_serial_rx

// [tb/qdl_host_model.sv]
module qdl_host_model (
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdata_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Serial host, clock stands high between frames
    // ************************************************************
    // Half period of 18 ns keeps the serial clock under 30 MHz
    localparam int HALF_NS = 18;
    localparam int GAP_NS  = 300;

    // Idle levels before any frame
    initial begin
        sclk_o   = 1'b1;
        sync_n_o = 1'b1;
        sdata_o  = 1'b0;
    end

    // One frame; nbits below 16 aborts, above 16 adds junk edges
    task automatic frame(input logic [15:0] w, input int nbits);
        int i;
        #7;
        sync_n_o = 1'b0;
        for (i = 0; i < nbits; i++) begin
            if (i < 16) begin
                sdata_o = w[15-i];
            end else begin
                sdata_o = ~sdata_o; // Junk after the word
            end
            #HALF_NS sclk_o = 1'b0;
            #HALF_NS sclk_o = 1'b1;
        end
        #HALF_NS sync_n_o = 1'b1;
        sdata_o = ~sdata_o; // Released line does not keep its value
        #GAP_NS;
    endtask : frame

endmodule : qdl_host_model

// [tb/test_qdl_quad_dac_serial_loader.sv]
module test_qdl_quad_dac_serial_loader;
    timeunit 1ns;
    timeprecision 100ps;
    import qdl_pkg::*;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        clock_i;
    logic        rst_b_i;
    logic        sclk_i;
    logic        sync_n_i;
    logic        sdata_i;
    logic [11:0] dac_a_o;
    logic [11:0] dac_b_o;
    logic [11:0] dac_c_o;
    logic [11:0] dac_d_o;
    logic        outputs_hiz_o;
    logic        output_settled_o;
    logic        input_buffer_on_o;
    logic [7:0]  nar_dac_a;
    logic [7:0]  nar_dac_b;
    logic [7:0]  nar_dac_c;
    logic [7:0]  nar_dac_d;
    logic        nar_hiz;
    logic        nar_settled;
    logic        nar_buf_on;
    int          num_errors;
    int          total_checks;
    int          cycles;
    int          i;
    int          wake_cycles = 0;
    int          nar_wake_cycles = 0;

    qdl_quad_dac_serial_loader #(
        .DATA_BITS (12),
        .LOW_SUPPLY(1'b0)
    ) qdl_quad_dac_serial_loader_inst (
        .clock_i          (clock_i),
        .rst_b_i          (rst_b_i),
        .sclk_i           (sclk_i),
        .sync_n_i         (sync_n_i),
        .sdata_i          (sdata_i),
        .dac_a_o          (dac_a_o),
        .dac_b_o          (dac_b_o),
        .dac_c_o          (dac_c_o),
        .dac_d_o          (dac_d_o),
        .outputs_hiz_o    (outputs_hiz_o),
        .output_settled_o (output_settled_o),
        .input_buffer_on_o(input_buffer_on_o)
    );

    // Narrow variant on the same link, low supply wake time
    qdl_quad_dac_serial_loader #(
        .DATA_BITS (8),
        .LOW_SUPPLY(1'b1)
    ) narrow_qdl_quad_dac_serial_loader_inst (
        .clock_i          (clock_i),
        .rst_b_i          (rst_b_i),
        .sclk_i           (sclk_i),
        .sync_n_i         (sync_n_i),
        .sdata_i          (sdata_i),
        .dac_a_o          (nar_dac_a),
        .dac_b_o          (nar_dac_b),
        .dac_c_o          (nar_dac_c),
        .dac_d_o          (nar_dac_d),
        .outputs_hiz_o    (nar_hiz),
        .output_settled_o (nar_settled),
        .input_buffer_on_o(nar_buf_on)
    );

    qdl_host_model qdl_host_model_inst (
        .sclk_o  (sclk_i),
        .sync_n_o(sync_n_i),
        .sdata_o (sdata_i)
    );

    // Core clock, 40 ns
    initial clock_i = 1'b0;
    always #20 clock_i = ~clock_i;

    // Hang guard
    initial cycles = 0;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    // Cycles spent waking: driven again but not yet settled
    always @(negedge clock_i) begin
        if (outputs_hiz_o === 1'b0 && output_settled_o === 1'b0) begin
            wake_cycles++;
        end
        if (nar_hiz === 1'b0 && nar_settled === 1'b0) begin
            nar_wake_cycles++;
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] mk(input logic [1:0] ch,
                                       input logic pd, input logic ld,
                                       input logic [11:0] d);
        return {ch, pd, ld, d};
    endfunction : mk

    task automatic cmp_data(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flag

    task automatic cmp_count(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_count

    task automatic check_dacs(input logic [11:0] a, input logic [11:0] b,
                              input logic [11:0] c, input logic [11:0] d);
        cmp_data(dac_a_o, a);
        cmp_data(dac_b_o, b);
        cmp_data(dac_c_o, c);
        cmp_data(dac_d_o, d);
        cmp_data({4'h0, nar_dac_a}, {4'h0, a[11:4]});
        cmp_data({4'h0, nar_dac_b}, {4'h0, b[11:4]});
        cmp_data({4'h0, nar_dac_c}, {4'h0, c[11:4]});
        cmp_data({4'h0, nar_dac_d}, {4'h0, d[11:4]});
    endtask : check_dacs

    // Send a frame, then let the core see it
    task automatic wr(input logic [15:0] w, input int nbits);
        qdl_host_model_inst.frame(w, nbits);
        repeat (10) @(posedge clock_i);
        #1;
    endtask : wr

    // Hold reset eight cycles, release, check the power-on state
    task automatic do_reset();
        rst_b_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        check_dacs(12'h000, 12'h000, 12'h000, 12'h000);
        cmp_flag(outputs_hiz_o, 1'b0);
        cmp_flag(output_settled_o, 1'b1);
        cmp_flag(input_buffer_on_o, 1'b1);
        cmp_flag(nar_hiz, 1'b0);
        cmp_flag(nar_settled, 1'b1);
        cmp_flag(nar_buf_on, 1'b1);
    endtask : do_reset

    task automatic end_test(input string name);
        $display("Test %s finished", name);
    endtask : end_test

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        num_errors   = 0;
        total_checks = 0;
        do_reset();
        end_test("reset");
        // Input register only, buffers drop after the word
        wr(mk(2'h0, 1'b1, 1'b1, 12'hABC), 16);
        check_dacs(12'h000, 12'h000, 12'h000, 12'h000);
        cmp_flag(input_buffer_on_o, 1'b0);
        end_test("input_only");
        // Three staged writes, fourth loads all
        wr(mk(2'h1, 1'b1, 1'b1, 12'h123), 16);
        wr(mk(2'h2, 1'b1, 1'b1, 12'hFFF), 16);
        wr(mk(2'h3, 1'b1, 1'b0, 12'h001), 16);
        check_dacs(12'hABC, 12'h123, 12'hFFF, 12'h001);
        end_test("load_all");
        // Aborted frame leaves input registers alone
        wr(mk(2'h1, 1'b1, 1'b0, 12'h555), 10);
        check_dacs(12'hABC, 12'h123, 12'hFFF, 12'h001);
        cmp_flag(input_buffer_on_o, 1'b1);
        wr(mk(2'h0, 1'b1, 1'b0, 12'h800), 16);
        check_dacs(12'h800, 12'h123, 12'hFFF, 12'h001);
        cmp_flag(input_buffer_on_o, 1'b0);
        end_test("abort");
        // Junk edges after the sixteenth are ignored
        wr(mk(2'h2, 1'b1, 1'b0, 12'h0F0), 20);
        check_dacs(12'h800, 12'h123, 12'h0F0, 12'h001);
        end_test("extra_edges");
        // Power-down keeps registers, wake delay on exit
        wr(mk(2'h3, 1'b0, 1'b1, 12'h777), 16);
        cmp_flag(outputs_hiz_o, 1'b1);
        cmp_flag(output_settled_o, 1'b0);
        cmp_flag(nar_hiz, 1'b1);
        check_dacs(12'h800, 12'h123, 12'h0F0, 12'h001);
        wr(mk(2'h3, 1'b1, 1'b0, 12'h777), 16);
        cmp_flag(outputs_hiz_o, 1'b0);
        cmp_flag(nar_hiz, 1'b0);
        check_dacs(12'h800, 12'h123, 12'h0F0, 12'h777);
        cmp_flag(output_settled_o, 1'b0);
        for (i = 0; i < 200 && (output_settled_o !== 1'b1
                || nar_settled !== 1'b1); i++) begin
            @(posedge clock_i);
            #1;
        end
        cmp_flag(output_settled_o, 1'b1);
        cmp_flag(nar_settled, 1'b1);
        cmp_count(wake_cycles, WAKE_5V_CYC);
        cmp_count(nar_wake_cycles, WAKE_3V_CYC);
        end_test("power_down");
        // Reset in mid-run clears everything again
        @(posedge clock_i);
        do_reset();
        end_test("mid_run_reset");
        give_verdict();
    end

endmodule : test_qdl_quad_dac_serial_loader
